//--- bench/ddr_ctrl_model.sv
// Purpose: Controller model driving mode words and write beats
// Assumes: Caller leaves a capture finished before the next one
// Notes: Idle data lines flip every cycle so stale beats never match
`timescale 1ns/1ns
module ddr_ctrl_model (
  // Clock
  input wire logic clk,
  // Command and data
  output logic emrs,
  output logic [12:0] addr,
  output logic wr,
  output logic [15:0] dq_r,
  output logic [15:0] dq_f
);
  logic busy = 1'b0;
  initial begin
    emrs = 1'b0;
    addr = 13'h0000;
    wr = 1'b0;
    dq_r = 16'h0000;
    dq_f = 16'hFFFF;
  end
  // Released data lines toggle
  always @(posedge clk) begin
    if (!busy) begin
      dq_r <= ~dq_r;
      dq_f <= ~dq_f;
    end
  end
  // One mode word load, pulse of one cycle
  task cmd(input logic [12:0] w);
    @(posedge clk);
    emrs <= 1'b1;
    addr <= w;
    @(posedge clk);
    emrs <= 1'b0;
  endtask : cmd
  // Write of a four beat code, same on all lines
  task code(input logic [3:0] c, input int wl);
    @(posedge clk);
    busy = 1'b1;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (wl - 1) @(posedge clk);
    dq_r <= {16{c[3]}};
    dq_f <= {16{c[2]}};
    @(posedge clk);
    dq_r <= {16{c[1]}};
    dq_f <= {16{c[0]}};
    @(posedge clk);
    busy = 1'b0;
  endtask : code
endmodule : ddr_ctrl_model

//--- bench/ocd_odt_ctrl_tb_top.sv
// Purpose: Self-checking bench for driver calibration and termination
// Assumes: Zero wait register port, turn-on interval set to 3
// Notes: Steps are tracked by a local saturating model
`timescale 1ns/1ns
module ocd_odt_ctrl_tb_top
  import ocd_odt_pkg::*;
;
  logic CLOCK, RST_N, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic emrs, cwr, sref, odt_pin, us, ls, usc, lsc;
  logic [12:0] caddr;
  logic [2:0] cas_lat;
  logic [15:0] dqr, dqf, dq_out;
  logic dq_oe_n, s_oe_n, sc_oe_n, odt_en, o75, o150, e;
  logic [3:0] pu, pd, epu, epd;
  int fails, tests_run, cyc, n;
  ocd_odt_ctrl uut (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRDATA(hrdata), .HRESP(hresp), .CMD_EMRS(emrs), .CMD_ADDR(caddr),
    .CMD_WRITE(cwr), .CAS_LAT(cas_lat), .SELF_REFRESH(sref),
    .ODT_PIN(odt_pin), .DQ_RISE(dqr), .DQ_FALL(dqf), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n), .UPPER_BYTE_STROBE(us), .LOWER_BYTE_STROBE(ls),
    .UPPER_BYTE_STROBE_C(usc), .LOWER_BYTE_STROBE_C(lsc),
    .STROBE_OE_N(s_oe_n), .STROBE_C_OE_N(sc_oe_n), .PULL_UP_STEP(pu),
    .PULL_DOWN_STEP(pd), .ODT_EN(odt_en), .ODT_75_EN(o75),
    .ODT_150_EN(o150));
  ddr_ctrl_model ctl (.clk(CLOCK), .emrs(emrs), .addr(caddr), .wr(cwr),
    .dq_r(dqr), .dq_f(dqf));
  // Clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // Hang guard
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // Single word transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge CLOCK); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge CLOCK); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Cycles until the data drivers reach a level
  task wait_oe(input logic lv);
    n = 0;
    do begin
      @(posedge CLOCK);
      #1;
      n++;
    end while (dq_oe_n !== lv && n < 20);
  endtask : wait_oe
  function automatic logic [3:0] sat(logic [3:0] v, logic up, logic dn);
    if (up && v != STEP_MAX) return v + 4'h1;
    if (dn && v != 4'h0) return v - 4'h1;
    return v;
  endfunction : sat
  task t_regs;
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, {20'h0, STEP_DEFAULT, STEP_DEFAULT, 4'h0});
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, ADDR_OIT, 32'h0);
    chk(rd, {24'h0, OIT_RESET});
    ahb(1'b1, ADDR_OIT, 32'h3);
    ahb(1'b1, 8'h0C, 32'hFF);
    ahb(1'b0, ADDR_OIT, 32'h0);
    chk(rd, 32'h3);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task t_drive;
    for (int m = 0; m < 2; m++) begin
      ctl.cmd({2'h0, m[0], m[0] ? CAL_DRV0 : CAL_DRV1, 7'h0});
      wait_oe(1'b0);
      chk(n, 3);
      chk(dq_out, m[0] ? 16'h0000 : 16'hFFFF);
      chk({us, ls, usc, lsc}, m[0] ? 4'h3 : 4'hC);
      chk({s_oe_n, sc_oe_n}, {1'b0, m[0]});
      ctl.cmd(13'h0000);
      wait_oe(1'b1);
      chk(n, 3);
    end
    $display("test drive done");
  endtask : t_drive
  task t_adjust;
    logic [3:0] c;
    logic [3:0] tbl [10];
    tbl = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'hA, 4'h0, 4'h3};
    epu = STEP_DEFAULT;
    epd = STEP_DEFAULT;
    ctl.cmd(13'h0008);
    ctl.cmd({3'h0, CAL_ADJ, 7'h0});
    for (int i = 0; i < 35; i++) begin
      c = i < 10 ? tbl[i] : (i < 18 ? 4'h5 : 4'hA);
      ctl.code(c, 3);
      #1;
      if (!(c[0] && c[1]) && !(c[2] && c[3])) begin
        epu = sat(epu, c[0], c[1]);
        epd = sat(epd, c[2], c[3]);
      end
      chk({pu, pd}, {epu, epd});
    end
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
    ctl.cmd(13'h0000);
    ctl.cmd({3'h0, CAL_DFLT, 7'h0});
    @(posedge CLOCK);
    #1;
    chk({pu, pd}, {STEP_DEFAULT, STEP_DEFAULT});
    ctl.cmd(13'h0000);
    $display("test adjust done");
  endtask : t_adjust
  task t_odt;
    for (int k = 0; k < 8; k++) begin
      ctl.cmd(k[2] ? 13'h0040 : 13'h0004);
      @(posedge CLOCK);
      odt_pin <= k[0];
      sref <= k[1];
      repeat (2) @(posedge CLOCK);
      #1;
      e = k[0] & !k[1];
      chk({odt_en, o75, o150}, {e, e & !k[2], e & k[2]});
    end
    ahb(1'b0, ADDR_EMR, 32'h0);
    chk(rd, {19'h0, 13'h0040});
    $display("test odt done");
  endtask : t_odt
  task end_of_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    RST_N = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cas_lat = 3'h3;
    sref = 1'b0;
    odt_pin = 1'b0;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_regs();
    t_drive();
    t_adjust();
    t_odt();
    end_of_test();
  end
endmodule : ocd_odt_ctrl_tb_top

//--- rtl/ocd_odt_ctrl.sv
// Purpose: Driver impedance calibration and termination control
// Assumes: Command, data and termination pins are synchronous to CLOCK;
//   two data beats per clock arrive on the rise and fall inputs
// Notes: Adjust code is read from data bit 0, all lines carry it
`timescale 1ns/1ns
module ocd_odt_ctrl
  import ocd_odt_pkg::*;
#(
  parameter int DQ_W = 16
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // Command side
  input wire logic CMD_EMRS,
  input wire logic [12:0] CMD_ADDR,
  input wire logic CMD_WRITE,
  input wire logic [2:0] CAS_LAT,
  input wire logic SELF_REFRESH,
  input wire logic ODT_PIN,
  // Write data beats
  input wire logic [DQ_W-1:0] DQ_RISE,
  input wire logic [DQ_W-1:0] DQ_FALL,
  // Output drivers
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  output logic UPPER_BYTE_STROBE,
  output logic LOWER_BYTE_STROBE,
  output logic UPPER_BYTE_STROBE_C,
  output logic LOWER_BYTE_STROBE_C,
  output logic STROBE_OE_N,
  output logic STROBE_C_OE_N,
  // Strength and termination
  output logic [3:0] PULL_UP_STEP,
  output logic [3:0] PULL_DOWN_STEP,
  output logic ODT_EN,
  output logic ODT_75_EN,
  output logic ODT_150_EN
);

  typedef struct packed {
    mode_e mode;
    logic [12:0] emr;
    logic [3:0] pu;
    logic [3:0] pd;
    logic [7:0] oit_cnt;
    logic drv_tgt;
    logic drv_on;
    logic lvl;
    cap_e cap;
    logic [4:0] wl_cnt;
    logic [1:0] beat01;
    logic [7:0] oit_cfg;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic odt;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Adjust code to {pull-up op, pull-down op}
  function automatic logic [3:0] decode_code(input logic [3:0] code);
    unique case (code)
      4'h1: decode_code = {OP_INC, OP_NOP};
      4'h2: decode_code = {OP_DEC, OP_NOP};
      4'h4: decode_code = {OP_NOP, OP_INC};
      4'h8: decode_code = {OP_NOP, OP_DEC};
      4'h5: decode_code = {OP_INC, OP_INC};
      4'h6: decode_code = {OP_DEC, OP_INC};
      4'h9: decode_code = {OP_INC, OP_DEC};
      4'hA: decode_code = {OP_DEC, OP_DEC};
      default: decode_code = {OP_NOP, OP_NOP};
    endcase
  endfunction : decode_code

  // Saturating strength step
  function automatic logic [3:0] step(input logic [3:0] v,
                                      input logic [1:0] op);
    step = v;
    if (op == OP_INC && v != STEP_MAX) begin
      step = v + 4'h1;
    end else if (op == OP_DEC && v != 4'h0) begin
      step = v - 4'h1;
    end
  endfunction : step

  logic [2:0] cal;
  logic [4:0] wl;
  logic [3:0] code;
  logic [3:0] ops;
  logic apply;
  logic dflt;
  logic addr_ph;

  // Command decode and derived values
  assign cal = CMD_ADDR[CAL_LSB+2:CAL_LSB];
  assign wl = {2'h0, s_q.emr[AL_LSB+2:AL_LSB]} + {2'h0, CAS_LAT} - 5'h01;
  assign code = {s_q.beat01, DQ_RISE[0], DQ_FALL[0]};
  assign ops = decode_code(code);
  assign apply = (s_q.cap == C_HALF2);
  assign dflt = CMD_EMRS && cal == CAL_DFLT;
  assign addr_ph = HSEL && HREADY && HTRANS[1];

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Calibration commands
    if (CMD_EMRS) begin
      s_d.emr = CMD_ADDR;
      if (cal == CAL_ADJ) begin
        s_d.emr[AL_LSB+2:AL_LSB] = s_q.emr[AL_LSB+2:AL_LSB];
      end
      unique case (cal)
        CAL_DRV1, CAL_DRV0: begin
          s_d.mode = (cal == CAL_DRV1) ? M_DRV1 : M_DRV0;
          s_d.lvl = (cal == CAL_DRV1);
          s_d.drv_tgt = 1'b1;
          s_d.oit_cnt = (s_q.oit_cfg == 8'h00) ? 8'h01 : s_q.oit_cfg;
        end
        CAL_ADJ: begin
          s_d.mode = M_ADJ;
        end
        CAL_EXIT: begin
          s_d.mode = M_OFF;
          s_d.cap = C_IDLE;
          if (s_q.drv_on || s_q.drv_tgt) begin
            s_d.drv_tgt = 1'b0;
            s_d.oit_cnt = (s_q.oit_cfg == 8'h00) ? 8'h01 : s_q.oit_cfg;
          end
        end
        CAL_DFLT: begin
          s_d.mode = M_OFF;
          s_d.pu = STEP_DEFAULT;
          s_d.pd = STEP_DEFAULT;
        end
        default: begin
          s_d.mode = s_q.mode;
        end
      endcase
    end
    // Output turn-on and turn-off interval
    if (s_q.oit_cnt != 8'h00) begin
      s_d.oit_cnt = s_q.oit_cnt - 8'h01;
      if (s_q.oit_cnt == 8'h01) begin
        s_d.drv_on = s_q.drv_tgt;
      end
    end
    // Adjust code capture at write latency
    unique case (s_q.cap)
      C_IDLE: begin
        if (CMD_WRITE && s_q.mode == M_ADJ && !CMD_EMRS) begin
          s_d.cap = C_WAIT;
          s_d.wl_cnt = (wl <= 5'h01) ? 5'h00 : wl - 5'h01;
        end
      end
      C_WAIT: begin
        if (s_q.wl_cnt == 5'h00) begin
          s_d.beat01 = {DQ_RISE[0], DQ_FALL[0]};
          s_d.cap = C_HALF2;
        end else begin
          s_d.wl_cnt = s_q.wl_cnt - 5'h01;
        end
      end
      C_HALF2: begin
        s_d.cap = C_IDLE;
      end
      default: begin
        s_d.cap = C_IDLE;
      end
    endcase
    // Exit drops a capture still waiting for its beats
    if (CMD_EMRS && cal == CAL_EXIT) begin
      s_d.cap = C_IDLE;
    end
    // One strength pair for all drivers
    if (apply && !dflt) begin
      s_d.pu = step(s_q.pu, ops[3:2]);
      s_d.pd = step(s_q.pd, ops[1:0]);
    end
    // Termination switch
    s_d.odt = ODT_PIN && !SELF_REFRESH;
    // Register bus data phase write
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend && s_q.addr == ADDR_OIT) begin
      s_d.oit_cfg = HWDATA[7:0];
    end
    // Register bus address phase
    if (addr_ph) begin
      s_d.addr = HADDR[7:0];
      s_d.wr_pend = HWRITE;
      s_d.rdata = 32'h0000_0000;
      if (!HWRITE && HADDR[31:8] == 24'h00_0000) begin
        unique case (HADDR[7:0])
          ADDR_STATUS: s_d.rdata = {17'h0_0000, ODT_150_EN, ODT_75_EN,
                                    s_q.odt, s_q.pd, s_q.pu, 1'b0,
                                    s_q.drv_on, s_q.mode};
          ADDR_OIT: s_d.rdata = {24'h00_0000, s_q.oit_cfg};
          ADDR_EMR: s_d.rdata = {19'h0_0000, s_q.emr};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '{mode: M_OFF, emr: EMR_RESET, pu: STEP_DEFAULT,
               pd: STEP_DEFAULT, oit_cnt: 8'h00, drv_tgt: 1'b0,
               drv_on: 1'b0, lvl: 1'b0, cap: C_IDLE, wl_cnt: 5'h00,
               beat01: 2'h0, oit_cfg: OIT_RESET, wr_pend: 1'b0,
               addr: 8'h00, rdata: 32'h0000_0000, odt: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s_q.rdata;

  // Driver outputs from state
  assign DQ_OUT = {DQ_W{s_q.lvl}};
  assign DQ_OE_N = !s_q.drv_on;
  assign UPPER_BYTE_STROBE = s_q.lvl;
  assign LOWER_BYTE_STROBE = s_q.lvl;
  assign UPPER_BYTE_STROBE_C = !s_q.lvl;
  assign LOWER_BYTE_STROBE_C = !s_q.lvl;
  assign STROBE_OE_N = !s_q.drv_on;
  assign STROBE_C_OE_N = !(s_q.drv_on && !s_q.emr[DQS_DIS]);
  assign PULL_UP_STEP = s_q.pu;
  assign PULL_DOWN_STEP = s_q.pd;

  // Termination value select
  assign ODT_EN = s_q.odt;
  assign ODT_75_EN = s_q.odt &&
    ({s_q.emr[RTT_HI], s_q.emr[RTT_LO]} == RTT_75);
  assign ODT_150_EN = s_q.odt &&
    ({s_q.emr[RTT_HI], s_q.emr[RTT_LO]} == RTT_150);

  // Checks
  property p_drv1_entry;
    @(posedge CLOCK) disable iff (!RST_N)
    (CMD_EMRS && cal == CAL_DRV1) |=> (s_q.mode == M_DRV1 && s_q.lvl);
  endproperty
  a_drv1_entry: assert property (p_drv1_entry)
    else $error("drive high entry not decoded");

  property p_drive_levels;
    @(posedge CLOCK) disable iff (!RST_N)
    (!DQ_OE_N && s_q.mode == M_DRV0) |-> (DQ_OUT == '0 &&
      UPPER_BYTE_STROBE_C && !LOWER_BYTE_STROBE);
  endproperty
  a_drive_levels: assert property (p_drive_levels)
    else $error("drive low levels wrong");

  property p_comp_enable;
    @(posedge CLOCK) disable iff (!RST_N)
    !STROBE_C_OE_N |-> (!STROBE_OE_N && !s_q.emr[DQS_DIS]);
  endproperty
  a_comp_enable: assert property (p_comp_enable)
    else $error("complement strobe driven while disabled");

  property p_no_wrap;
    @(posedge CLOCK) disable iff (!RST_N)
    ($past(PULL_UP_STEP) == STEP_MAX |-> PULL_UP_STEP != 4'h0) and
    ($past(PULL_DOWN_STEP) == 4'h0 |-> PULL_DOWN_STEP != STEP_MAX);
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("strength step wrapped");

  property p_pu_inc;
    @(posedge CLOCK) disable iff (!RST_N)
    (apply && !dflt && code == 4'h1 && s_q.pu != STEP_MAX) |=>
      (PULL_UP_STEP == $past(PULL_UP_STEP) + 4'h1 &&
       $stable(PULL_DOWN_STEP));
  endproperty
  a_pu_inc: assert property (p_pu_inc)
    else $error("pull-up increment code ignored");

  property p_steps_hold;
    @(posedge CLOCK) disable iff (!RST_N)
    (!apply && !dflt) |=> ($stable(PULL_UP_STEP) &&
      $stable(PULL_DOWN_STEP));
  endproperty
  a_steps_hold: assert property (p_steps_hold)
    else $error("strength changed without a code");

  property p_oit_on;
    @(posedge CLOCK) disable iff (!RST_N)
    (CMD_EMRS && cal == CAL_DRV1 && s_q.oit_cnt == 8'h00 &&
     s_q.oit_cfg == 8'h03 && !s_q.drv_on) |=>
      DQ_OE_N ##1 DQ_OE_N ##1 DQ_OE_N ##1 !DQ_OE_N;
  endproperty
  a_oit_on: assert property (p_oit_on)
    else $error("outputs not on after turn-on interval");

  property p_odt_self_refresh;
    @(posedge CLOCK) disable iff (!RST_N)
    (SELF_REFRESH ##1 SELF_REFRESH) |-> !ODT_EN;
  endproperty
  a_odt_self_refresh: assert property (p_odt_self_refresh)
    else $error("termination on in self refresh");

  property p_odt_value;
    @(posedge CLOCK) disable iff (!RST_N)
    ODT_75_EN |-> (ODT_EN && !ODT_150_EN && !s_q.emr[RTT_HI] &&
      s_q.emr[RTT_LO]);
  endproperty
  a_odt_value: assert property (p_odt_value)
    else $error("termination value select wrong");

  property p_odt_follow;
    @(posedge CLOCK) disable iff (!RST_N)
    (ODT_PIN && !SELF_REFRESH) |=> ODT_EN;
  endproperty
  a_odt_follow: assert property (p_odt_follow)
    else $error("termination does not follow pin");

endmodule : ocd_odt_ctrl

//--- shared/ocd_odt_pkg.sv
// Purpose: Shared constants and types for the driver calibration block
// Assumes: 32-bit AHB-Lite register port, 13-bit extended mode word
// Notes: Register offsets are byte addresses
package ocd_odt_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OIT = 8'h04;
  localparam logic [7:0] ADDR_EMR = 8'h08;
  // Extended mode word field positions
  localparam int CAL_LSB = 7;
  localparam int AL_LSB = 3;
  localparam int RTT_HI = 6;
  localparam int RTT_LO = 2;
  localparam int DQS_DIS = 10;
  // Calibration field codes
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DRV1 = 3'h1;
  localparam logic [2:0] CAL_DRV0 = 3'h2;
  localparam logic [2:0] CAL_ADJ = 3'h4;
  localparam logic [2:0] CAL_DFLT = 3'h7;
  // Termination select patterns {A6,A2}
  localparam logic [1:0] RTT_75 = 2'h1;
  localparam logic [1:0] RTT_150 = 2'h2;
  // Reset values and step limit
  localparam logic [7:0] OIT_RESET = 8'h02;
  localparam logic [3:0] STEP_DEFAULT = 4'h8;
  localparam logic [3:0] STEP_MAX = 4'hF;
  localparam logic [12:0] EMR_RESET = 13'h0000;
  // Step operations
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_INC = 2'h1;
  localparam logic [1:0] OP_DEC = 2'h2;
  typedef enum logic [1:0] {M_OFF, M_DRV1, M_DRV0, M_ADJ} mode_e;
  typedef enum logic [1:0] {C_IDLE, C_WAIT, C_HALF2} cap_e;
endpackage : ocd_odt_pkg
